// ===== rtl/tla_regs.svh
// register offsets, field positions, reset values and timing constants
`ifndef TLA_REGS_SVH
`define TLA_REGS_SVH
`define TLA_OFS_TEMP_HI 8'h00
`define TLA_OFS_FLAGS 8'h01
`define TLA_OFS_TEMP_LO 8'h02
`define TLA_OFS_SETUP 8'h03
`define TLA_OFS_RATE 8'h04
`define TLA_OFS_UPHI 8'h05
`define TLA_OFS_UPLO 8'h06
`define TLA_OFS_LOHI 8'h07
`define TLA_OFS_LOLO 8'h08
`define TLA_OFS_ONESHOT 8'h0f
`define TLA_OFS_OTLIM 8'h20
`define TLA_OFS_OTHYS 8'h21
`define TLA_OFS_TMO 8'h22
`define TLA_OFS_PART 8'hfd
`define TLA_OFS_MAKER 8'hfe
`define TLA_OFS_REV 8'hff
`define TLA_RST_ZERO 8'h00
`define TLA_RST_RATE 8'h04
`define TLA_RST_UPHI 8'h55
`define TLA_RST_OTLIM 8'h55
`define TLA_RST_OTHYS 8'h0a
`define TLA_RST_TMO 8'h01
`define TLA_SETUP_MASK 7
`define TLA_SETUP_STBY 6
`define TLA_SETUP_T2 5
`define TLA_FLAG_BUSY 7
`define TLA_FLAG_ABOVE 6
`define TLA_FLAG_BELOW 5
`define TLA_FLAG_OT 0
`define TLA_TMO_EN 7
`define TLA_RATE_MAX 4'h9
`define TLA_CLK_NS 5
`define TLA_RATE_TICK_NS 31250000
`endif

// ===== rtl/tla_pkg.sv
// shared types of the temperature limit and alert block
package tla_pkg;
  typedef enum logic [1:0] {
    TLA_IDLE = 2'b00,
    TLA_WAIT = 2'b01,
    TLA_CONV = 2'b10
  } tla_state_t;
  typedef logic [9:0] tla_temp_t;
  typedef logic [7:0] tla_byte_t;
endpackage

// ===== rtl/tla_cmp_if.sv
// limits and stored temperature to the comparator, conditions back
`timescale 1ns/1ps
interface tla_cmp_if;
  import tla_pkg::*;
  tla_temp_t temp;
  tla_temp_t hi_lim;
  tla_temp_t lo_lim;
  tla_byte_t ot_lim;
  tla_byte_t hyst;
  logic above;
  logic below;
  logic t2_release;
  logic ot_above;
  logic ot_release;
  modport cmp (input temp, hi_lim, lo_lim, ot_lim, hyst,
    output above, below, t2_release, ot_above, ot_release);
  modport ctl (output temp, hi_lim, lo_lim, ot_lim, hyst,
    input above, below, t2_release, ot_above, ot_release);
endinterface

// ===== rtl/tla_compare.sv
// signed window, thermostat and hysteresis comparisons
`timescale 1ns/1ps
module tla_compare
  import tla_pkg::*;
(
  tla_cmp_if.cmp c
);
  logic signed [11:0] t2_thr;
  logic signed [8:0] ot_thr;

  // hysteresis is in whole degrees, so shift it onto the quarter-degree scale
  assign t2_thr = $signed({{2{c.hi_lim[9]}}, c.hi_lim})
    - $signed({{2{c.hyst[7]}}, c.hyst, 2'b00});
  assign ot_thr = $signed({c.ot_lim[7], c.ot_lim})
    - $signed({c.hyst[7], c.hyst});

  // window: at or below low limit, strictly above high limit
  assign c.above = $signed(c.temp) > $signed(c.hi_lim);
  assign c.below = $signed(c.temp) <= $signed(c.lo_lim);
  assign c.t2_release = $signed({{2{c.temp[9]}}, c.temp}) < t2_thr;
  // over-temperature limit is compared with the integer-degree byte only
  assign c.ot_above = $signed(c.temp[9:2]) > $signed(c.ot_lim);
  assign c.ot_release = $signed({c.temp[9], c.temp[9:2]}) < ot_thr;
endmodule

// ===== rtl/tla_top.sv
// register file, conversion sequencing and alert outputs of the sensor
`timescale 1ns/1ps
`include "tla_regs.svh"

// Notes on behaviour
// - alert on temp at/below low or above high
// - alert response releases only when condition cleared
// - mask blocks alert except in thermostat mode
// - thermostat mode: set above high, hysteresis release
// - overtemp output above limit, never masked
// - overtemp holds until below limit minus hysteresis
// - standby stops conversions, registers stay accessible
// - standby accepts a single measurement request
// - limit rewrites re-evaluate stored temperature
// - register map at documented byte addresses
// - unassigned reads zero, writes ignored
// - reset loads every default value
// - high byte read freezes low byte
// - status read-only, busy bit, reserved bits
// - high and low flags drive unmasked alert
// - status bit 0 flags over-temperature
// - status read clears only vanished conditions
// - setup bits: mask, standby, thermostat mode
// - one-shot ignored in run, single run in standby
module tla_top
  import tla_pkg::*;
#(
  parameter int unsigned RATE_TICK_CYC = `TLA_RATE_TICK_NS / `TLA_CLK_NS,
  parameter logic [7:0] PART_ID = 8'h5a, // arbitrary value
  parameter logic [7:0] MAKER_ID = 8'ha5, // arbitrary value
  parameter logic [7:0] REV_ID = 8'h01 // arbitrary value
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic ara_i,
  output logic ara_ack_o,
  output logic adc_en_o,
  output logic conv_req_o,
  input wire logic adc_done_i,
  input wire logic [9:0] adc_temp_i,
  input wire logic limit_alert_in_i,
  output logic limit_alert_out_o,
  output logic limit_alert_oe_n_o,
  input wire logic overtemp_in_i,
  output logic overtemp_out_o,
  output logic overtemp_oe_n_o,
  output logic smb_timeout_en_o
);
  if (RATE_TICK_CYC < 1) begin : g_chk
    $error("RATE_TICK_CYC must be at least one");
  end

  tla_cmp_if cmp ();
  tla_state_t state_r;
  tla_state_t state_nxt;
  tla_byte_t setup_r;
  tla_byte_t rate_r;
  tla_byte_t uphi_r;
  logic [1:0] uplo_r;
  tla_byte_t lohi_r;
  logic [1:0] lolo_r;
  tla_byte_t otlim_r;
  tla_byte_t othys_r;
  tla_byte_t tmo_r;
  tla_byte_t temp_hi_r;
  logic [1:0] lo_live_r;
  logic [1:0] lo_vis_r;
  logic lock_r;
  logic above_flag_r;
  logic below_flag_r;
  logic overtemp_flag_r;
  logic [31:0] tick_cnt_r;
  logic [9:0] tick_num_r;
  logic [9:0] tick_lim;
  logic [3:0] rate_code;
  logic standby;
  logic t2_mode;
  logic wr_setup;
  logic oneshot_wr;
  logic rd_flags;
  logic rd_hi;
  logic rd_lo;
  logic interval_done;
  logic alert_cause;
  logic alert_clear_ok;
  tla_byte_t rd_nxt;
  tla_byte_t flags_view;

  // decoded setup bits and register access strobes
  assign standby = setup_r[`TLA_SETUP_STBY];
  assign t2_mode = setup_r[`TLA_SETUP_T2];
  assign wr_setup = reg_wr_i && (reg_addr_i == `TLA_OFS_SETUP);
  assign oneshot_wr = reg_wr_i && (reg_addr_i == `TLA_OFS_ONESHOT);
  assign rd_flags = reg_rd_i && (reg_addr_i == `TLA_OFS_FLAGS);
  assign rd_hi = reg_rd_i && (reg_addr_i == `TLA_OFS_TEMP_HI);
  assign rd_lo = reg_rd_i && (reg_addr_i == `TLA_OFS_TEMP_LO);

  // limits feed the comparator straight from the registers, so any rewrite
  // re-evaluates the last stored temperature at once, in any mode
  assign cmp.temp = {temp_hi_r, lo_live_r};
  assign cmp.hi_lim = {uphi_r, uplo_r};
  assign cmp.lo_lim = {lohi_r, lolo_r};
  assign cmp.ot_lim = otlim_r;
  assign cmp.hyst = othys_r;

  tla_compare u_cmp (
    .c (cmp.cmp)
  );

  // writable registers; unassigned and read-only offsets ignore writes
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      setup_r <= `TLA_RST_ZERO;
      rate_r <= `TLA_RST_RATE;
      uphi_r <= `TLA_RST_UPHI;
      uplo_r <= 2'b00;
      lohi_r <= `TLA_RST_ZERO;
      lolo_r <= 2'b00;
      otlim_r <= `TLA_RST_OTLIM;
      othys_r <= `TLA_RST_OTHYS;
      tmo_r <= `TLA_RST_TMO;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `TLA_OFS_SETUP: setup_r <= {reg_wdata_i[7:5], 5'h00};
        `TLA_OFS_RATE: rate_r <= reg_wdata_i;
        `TLA_OFS_UPHI: uphi_r <= reg_wdata_i;
        `TLA_OFS_UPLO: uplo_r <= reg_wdata_i[7:6];
        `TLA_OFS_LOHI: lohi_r <= reg_wdata_i;
        `TLA_OFS_LOLO: lolo_r <= reg_wdata_i[7:6];
        `TLA_OFS_OTLIM: otlim_r <= reg_wdata_i;
        `TLA_OFS_OTHYS: othys_r <= reg_wdata_i;
        `TLA_OFS_TMO: tmo_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // interval between run-mode conversions: 2^(9-code) ticks of 1/32 s;
  // reserved codes run at the fastest documented rate
  assign rate_code = (rate_r > {4'h0, `TLA_RATE_MAX}) ? `TLA_RATE_MAX : rate_r[3:0];
  assign tick_lim = 10'h001 << (`TLA_RATE_MAX - rate_code);
  assign interval_done = (tick_num_r == tick_lim - 10'h001)
    && (tick_cnt_r == RATE_TICK_CYC - 1);

  // tick counters run only while waiting between conversions
  always_ff @(posedge clk_i) begin
    if (srst_i || state_r != TLA_WAIT) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_num_r <= 10'h000;
    end else if (tick_cnt_r == RATE_TICK_CYC - 1) begin
      tick_cnt_r <= 32'h0000_0000;
      tick_num_r <= tick_num_r + 10'h001;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end

  // conversion sequencer; a conversion in flight finishes even if
  // standby is set meanwhile, so the stored temperature stays whole
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      TLA_IDLE: begin
        if (!standby) begin
          state_nxt = TLA_CONV;
        end else if (oneshot_wr) begin
          state_nxt = TLA_CONV;
        end
      end
      TLA_WAIT: begin
        if (standby) begin
          state_nxt = TLA_IDLE;
        end else if (interval_done) begin
          state_nxt = TLA_CONV;
        end
      end
      TLA_CONV: begin
        if (adc_done_i) begin
          state_nxt = standby ? TLA_IDLE : TLA_WAIT;
        end
      end
      default: state_nxt = TLA_IDLE;
    endcase
  end

  // state register; one-shot writes in run mode fall through unused
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_r <= TLA_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // request pulse to the converter and its power enable
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      conv_req_o <= 1'b0;
      adc_en_o <= 1'b0;
    end else begin
      conv_req_o <= (state_r != TLA_CONV) && (state_nxt == TLA_CONV);
      adc_en_o <= !standby || (state_nxt == TLA_CONV);
    end
  end

  // measured temperature capture
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      temp_hi_r <= `TLA_RST_ZERO;
      lo_live_r <= 2'b00;
    end else if (state_r == TLA_CONV && adc_done_i) begin
      temp_hi_r <= adc_temp_i[9:2];
      lo_live_r <= adc_temp_i[1:0];
    end
  end

  // read interlock: a high-byte read freezes the visible low byte until
  // the low byte is read; a low read with no high read pending returns the live bits
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_r <= 1'b0;
      lo_vis_r <= 2'b00;
    end else if (rd_hi) begin
      lock_r <= 1'b1;
      lo_vis_r <= lo_live_r;
    end else if (rd_lo) begin
      lock_r <= 1'b0;
    end else if (!lock_r) begin
      lo_vis_r <= lo_live_r;
    end
  end

  // status flags: a live condition always wins over a clearing read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      above_flag_r <= 1'b0;
      below_flag_r <= 1'b0;
      overtemp_flag_r <= 1'b0;
    end else begin
      if (cmp.above) begin
        above_flag_r <= 1'b1;
      end else if (rd_flags) begin
        above_flag_r <= 1'b0;
      end
      if (cmp.below) begin
        below_flag_r <= 1'b1;
      end else if (rd_flags) begin
        below_flag_r <= 1'b0;
      end
      if (cmp.ot_above) begin
        overtemp_flag_r <= 1'b1;
      end else if (rd_flags) begin
        overtemp_flag_r <= 1'b0;
      end
    end
  end

  // alert cause and release condition for the maskable alert mode
  assign alert_cause = (above_flag_r || below_flag_r)
    && !setup_r[`TLA_SETUP_MASK];
  assign alert_clear_ok = !above_flag_r && !below_flag_r
    && !cmp.above && !cmp.below;

  // limit alert pin, held as its active-low enable; mask ignored in
  // thermostat mode, latched until an alert response in alert mode
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      limit_alert_oe_n_o <= 1'b1;
    end else if (t2_mode) begin
      if (cmp.above) begin
        limit_alert_oe_n_o <= 1'b0;
      end else if (cmp.t2_release) begin
        limit_alert_oe_n_o <= 1'b1;
      end
    end else if (alert_cause) begin
      limit_alert_oe_n_o <= 1'b0;
    end else if (ara_i && alert_clear_ok) begin
      limit_alert_oe_n_o <= 1'b1;
    end
  end

  // alert response: answered in alert mode only, while this device holds the alert line
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ara_ack_o <= 1'b0;
    end else begin
      ara_ack_o <= ara_i && !t2_mode && !limit_alert_oe_n_o;
    end
  end

  // over-temperature pin, no mask, hysteresis release
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      overtemp_oe_n_o <= 1'b1;
    end else if (cmp.ot_above) begin
      overtemp_oe_n_o <= 1'b0;
    end else if (cmp.ot_release) begin
      overtemp_oe_n_o <= 1'b1;
    end
  end

  // open-drain data levels are always low; only the enables move
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      limit_alert_out_o <= 1'b0;
      overtemp_out_o <= 1'b0;
      smb_timeout_en_o <= 1'b0;
    end else begin
      limit_alert_out_o <= 1'b0;
      overtemp_out_o <= 1'b0;
      smb_timeout_en_o <= tmo_r[`TLA_TMO_EN];
    end
  end

  // status view: busy, window flags, over-temperature, reserved zero
  always_comb begin
    flags_view = 8'h00;
    flags_view[`TLA_FLAG_BUSY] = (state_r == TLA_CONV);
    flags_view[`TLA_FLAG_ABOVE] = above_flag_r;
    flags_view[`TLA_FLAG_BELOW] = below_flag_r;
    flags_view[`TLA_FLAG_OT] = overtemp_flag_r;
  end

  // read decode; write-only and unassigned offsets return zero
  always_comb begin
    unique case (reg_addr_i)
      `TLA_OFS_TEMP_HI: rd_nxt = temp_hi_r;
      `TLA_OFS_FLAGS: rd_nxt = flags_view;
      `TLA_OFS_TEMP_LO: rd_nxt = {lock_r ? lo_vis_r : lo_live_r, 6'h00};
      `TLA_OFS_SETUP: rd_nxt = setup_r;
      `TLA_OFS_RATE: rd_nxt = rate_r;
      `TLA_OFS_UPHI: rd_nxt = uphi_r;
      `TLA_OFS_UPLO: rd_nxt = {uplo_r, 6'h00};
      `TLA_OFS_LOHI: rd_nxt = lohi_r;
      `TLA_OFS_LOLO: rd_nxt = {lolo_r, 6'h00};
      `TLA_OFS_OTLIM: rd_nxt = otlim_r;
      `TLA_OFS_OTHYS: rd_nxt = othys_r;
      `TLA_OFS_TMO: rd_nxt = tmo_r;
      `TLA_OFS_PART: rd_nxt = PART_ID;
      `TLA_OFS_MAKER: rd_nxt = MAKER_ID;
      `TLA_OFS_REV: rd_nxt = REV_ID;
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data is registered; it holds until the next read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end
endmodule

// ===== tb/tla_top_assertions.sv
// concurrent checks on the ports of the sensor top
`timescale 1ns/1ps
module tla_top_assertions (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic ara_i,
  input wire logic ara_ack_o,
  input wire logic adc_en_o,
  input wire logic conv_req_o,
  input wire logic limit_alert_out_o,
  input wire logic limit_alert_oe_n_o,
  input wire logic overtemp_out_o,
  input wire logic overtemp_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // a read strobe at one address
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  property p_oneshot_rd;
    s_rd(8'h0f) |=> reg_rdata_o == 8'h00;
  endproperty
  a_oneshot_rd: assert property (p_oneshot_rd) else $error("one-shot read not zero");
  property p_unmapped_rd;
    reg_rd_i && ((reg_addr_i > 8'h08 && reg_addr_i < 8'h20 && reg_addr_i != 8'h0f)
      || (reg_addr_i > 8'h22 && reg_addr_i < 8'hfd)) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  property p_reserved;
    s_rd(8'h01) |=> reg_rdata_o[4:1] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bits set");
  property p_low_byte;
    s_rd(8'h02) |=> reg_rdata_o[5:0] == 6'h00;
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte padding not zero");
  property p_ack_cause;
    ara_ack_o |-> $past(ara_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without request");
  property p_ack_held;
    ara_i && limit_alert_oe_n_o |=> !ara_ack_o;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("answer while alert released");
  // first edge out of reset still shows the reset state
  property p_reset;
    $fell(srst_i) |-> limit_alert_oe_n_o && overtemp_oe_n_o && reg_rdata_o == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not at reset level");
  property p_open_drain;
    !limit_alert_out_o && !overtemp_out_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("pin driven high");
  property p_conv;
    conv_req_o |=> !conv_req_o && adc_en_o;
  endproperty
  a_conv: assert property (p_conv) else $error("bad conversion request");
endmodule

bind tla_top tla_top_assertions u_tla_top_assertions (.clk_i, .srst_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .ara_i, .ara_ack_o, .adc_en_o, .conv_req_o, .limit_alert_out_o,
  .limit_alert_oe_n_o, .overtemp_out_o, .overtemp_oe_n_o);

// ===== tb/tla_adc_model.sv
// converter and pull-up model on the far side of the sensor logic
`timescale 1ns/1ps
module tla_adc_model (
  input wire logic clk_i,
  input wire logic conv_req_i,
  input wire logic [9:0] temp_set_i,
  input wire logic a_out_i,
  input wire logic a_oe_n_i,
  input wire logic t_out_i,
  input wire logic t_oe_n_i,
  output logic adc_done_o,
  output logic [9:0] adc_temp_o,
  output wire logic a_pin_o,
  output wire logic t_pin_o
);
  logic [2:0] cnt_r = 3'h0;
  // answers four cycles after a request; data is junk outside the pulse
  always @(posedge clk_i) begin
    adc_done_o <= cnt_r == 3'h1;
    adc_temp_o <= (cnt_r == 3'h1) ? temp_set_i : ~temp_set_i;
    if (conv_req_i) begin
      cnt_r <= 3'h4;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
    end
  end
  // pull-ups hold released lines high
  assign a_pin_o = a_oe_n_i ? 1'b1 : a_out_i;
  assign t_pin_o = t_oe_n_i ? 1'b1 : t_out_i;
endmodule

// ===== tb/tb.sv
// self-checking bench of the sensor limit, alert and register logic
`timescale 1ns/1ps
module tb;
  import tla_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_rd_i = 1'b0;
  logic ara_i = 1'b0;
  logic [9:0] temp_set = 10'h000;
  logic [7:0] reg_rdata_o;
  logic ara_ack_o, adc_en_o, conv_req_o, adc_done_i, smb_timeout_en_o;
  logic limit_alert_out_o, limit_alert_oe_n_o, overtemp_out_o, overtemp_oe_n_o;
  logic limit_alert_in_i, overtemp_in_i;
  logic [9:0] adc_temp_i;
  int failures = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  // address beside its expected reset value
  logic [15:0] rows [16] = '{16'h0000, 16'h0200, 16'h0300, 16'h0404, 16'h0555, 16'h0600,
    16'h0700, 16'h0800, 16'h0f00, 16'h2055, 16'h210a, 16'h2201, 16'h1000, 16'hfd5a,
    16'hfea5, 16'hff01};
  // short rate tick keeps run-mode periods to a few hundred cycles
  tla_top #(.RATE_TICK_CYC(8)) u_tla_top (.clk_i, .srst_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .ara_i, .ara_ack_o, .adc_en_o, .conv_req_o,
    .adc_done_i, .adc_temp_i, .limit_alert_in_i, .limit_alert_out_o, .limit_alert_oe_n_o,
    .overtemp_in_i, .overtemp_out_o, .overtemp_oe_n_o, .smb_timeout_en_o);
  tla_adc_model u_tla_adc_model (.clk_i(clk_i), .conv_req_i(conv_req_o),
    .temp_set_i(temp_set), .a_out_i(limit_alert_out_o), .a_oe_n_i(limit_alert_oe_n_o),
    .t_out_i(overtemp_out_o), .t_oe_n_i(overtemp_oe_n_o), .adc_done_o(adc_done_i),
    .adc_temp_o(adc_temp_i), .a_pin_o(limit_alert_in_i), .t_pin_o(overtemp_in_i));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // hang guard, far above the expected run length
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  // read strobe, then data one edge later
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, e);
  endtask
  task automatic ara_chk(input logic e);
    @(posedge clk_i);
    ara_i <= 1'b1;
    @(posedge clk_i);
    ara_i <= 1'b0;
    #1 chk({7'h00, ara_ack_o}, {7'h00, e});
  endtask
  // pin levels as the pull-ups show them: alert, overtemp
  task automatic pins(input logic [1:0] e);
    repeat (3) @(posedge clk_i);
    #1 chk({6'h00, limit_alert_in_i, overtemp_in_i}, {6'h00, e});
  endtask
  task automatic one_shot;
    wr_reg(8'h0f, 8'h01);
    n = 0;
    while (adc_done_i !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      n = n + 1;
    end
    repeat (2) @(posedge clk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      rc(rows[i][15:8], rows[i][7:0]);
    end
    wr_reg(8'h10, 8'h33);
    wr_reg(8'h00, 8'h33);
    rc(8'h10, 8'h00);
    rc(8'h00, 8'h00);
    wr_reg(8'h03, 8'hff);
    rc(8'h03, 8'he0);
    wr_reg(8'h03, 8'h40);
    $display("registers done");
    // standby must stay quiet well past one run-mode period
    repeat (4) @(posedge clk_i);
    n = 0;
    repeat (600) begin
      @(posedge clk_i);
      #1 n = n + int'(conv_req_o);
    end
    chk(8'(n), 8'h00);
    chk({7'h00, adc_en_o}, 8'h00);
    temp_set <= 10'h191;
    wr_reg(8'h07, 8'hd8);
    rc(8'h01, 8'h20);
    one_shot();
    pins(2'b00);
    rc(8'h00, 8'h64);
    temp_set <= 10'h193;
    one_shot();
    rc(8'h02, 8'h40);
    rc(8'h00, 8'h64);
    rc(8'h02, 8'hc0);
    $display("one-shot done");
    wr_reg(8'h20, 8'h66);
    pins(2'b00);
    wr_reg(8'h20, 8'h6f);
    pins(2'b01);
    wr_reg(8'h05, 8'h70);
    ara_chk(1'b1);
    pins(2'b01);
    rc(8'h01, 8'h41);
    rc(8'h01, 8'h00);
    ara_chk(1'b1);
    pins(2'b11);
    // temperature equal to the low limit counts as out of range
    wr_reg(8'h07, 8'h64);
    wr_reg(8'h08, 8'hc0);
    pins(2'b01);
    wr_reg(8'h07, 8'hd8);
    rc(8'h01, 8'h20);
    ara_chk(1'b1);
    pins(2'b11);
    $display("alert done");
    wr_reg(8'h03, 8'hc0);
    wr_reg(8'h05, 8'h50);
    pins(2'b11);
    rc(8'h01, 8'h40);
    ara_chk(1'b0);
    wr_reg(8'h03, 8'he0);
    pins(2'b01);
    wr_reg(8'h05, 8'h68);
    pins(2'b01);
    wr_reg(8'h05, 8'h70);
    pins(2'b11);
    ara_chk(1'b0);
    $display("thermostat done");
    // one-shot in standby: busy shows beside the still-set above flag
    wr_reg(8'h0f, 8'h01);
    rc(8'h01, 8'hc0);
    $display("busy done");
    // timeout enable follows bit 7, then a mid-run reset restores defaults
    wr_reg(8'h22, 8'h80);
    @(posedge clk_i);
    srst_i <= 1'b1;
    #1 chk({7'h00, smb_timeout_en_o}, 8'h01);
    repeat (4) @(posedge clk_i);
    srst_i <= 1'b0;
    rc(8'h03, 8'h00);
    rc(8'h05, 8'h55);
    rc(8'h21, 8'h0a);
    chk({7'h00, smb_timeout_en_o}, 8'h00);
    $display("reset done");
    wrap_up();
  end
endmodule
